//--- pkg/stepper_pkg.sv
// Constants, register map and types of the closed-loop stepper pulse control block
//
// Overview of operation
// RL1: In single-pulse mode each step pulse moves one step, clockwise while direction is active.
// RL2: In dual-pulse mode clockwise pulses step clockwise and counterclockwise pulses step back.
// RL3: While winding release is active every motor winding is de-energised.
// RL4: Activating winding release resets the deviation counter to zero.
// RL5: With a 1000 or 500 base the multiplier input raises resolution tenfold.
// RL6: With the switch already at tenfold the multiplier input is ignored.
// RL7: Alarm clear cancels a latched protection alarm without a power cycle.
// RL8: EEPROM data and system error alarms are never cleared by alarm clear.
// RL9: Completion needs the rotor within 1.8 degrees and about 2 ms without pulses.
// RL10: Completion is signalled conducting and is non-conducting otherwise.
// RL11: The controller waits 0.5 s after power-up before releasing the holding brake.
// RL12: An unconnected input is inactive and active means current through the photocoupler.
// RL13: A protection fault raises the alarm, blinks the indicator and frees the windings; a hard fault lights the indicator steadily instead.
// RL14: The alarm output is normally conducting and opens on alarm; others are normally off.
// RL15: Each accepted step adds to the commanded position scaled by the resolution in effect.
`default_nettype none

package stepper_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned SETTLE_US   = 2000;
	localparam int unsigned SETTLE_CYC  = CLK_HZ / 1_000_000 * SETTLE_US;
	localparam int unsigned BRAKE_MS    = 500;
	localparam int unsigned BRAKE_CYC   = CLK_HZ / 1000 * BRAKE_MS;
	localparam int unsigned BLINK_MS    = 250;
	localparam int unsigned BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;

	// ------------------------------------------------------------
	// Position scaling, in units of one ten-thousandth revolution
	// ------------------------------------------------------------
	localparam int unsigned FINE_PPR       = 10000;
	localparam int unsigned WINDOW_DEG_X10 = 18;
	localparam logic [31:0] WINDOW_UNITS   = 32'(FINE_PPR * WINDOW_DEG_X10 / 3600);
	localparam logic [31:0] STEP_FINE_1000 = 32'h0000_0001;
	localparam logic [31:0] STEP_FINE_500  = 32'h0000_0002;
	localparam logic [31:0] STEP_BASE_1000 = 32'h0000_000a;
	localparam logic [31:0] STEP_BASE_500  = 32'h0000_0014;

	// ------------------------------------------------------------
	// Synchronised pin indices
	// ------------------------------------------------------------
	localparam int PIN_COUNT = 8;
	localparam int PIN_STEP  = 0;
	localparam int PIN_DIR   = 1;
	localparam int PIN_REL   = 2;
	localparam int PIN_MULT  = 3;
	localparam int PIN_ACLR  = 4;
	localparam int PIN_DUAL  = 5;
	localparam int PIN_B500  = 6;
	localparam int PIN_SWX10 = 7;

	// ------------------------------------------------------------
	// Protection fault vector
	// ------------------------------------------------------------
	localparam int         FAULT_COUNT   = 7;
	localparam logic [6:0] FAULT_NOCLEAR = 7'h50;

	// ------------------------------------------------------------
	// Register map and status bits
	// ------------------------------------------------------------
	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_MASK      = 8'h04;
	localparam logic [7:0] REG_POSITION  = 8'h08;
	localparam logic [7:0] REG_DEVIATION = 8'h0c;
	localparam logic [7:0] REG_STATE     = 8'h10;
	localparam int         EV_COUNT      = 3;
	localparam int         EV_DONE       = 0;
	localparam int         EV_ALARM      = 1;
	localparam int         EV_CLEARED    = 2;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_ALARM  = 3'b010,
		ST_LOCKED = 3'b100
	} alarm_state_t;

endpackage

`default_nettype wire

//--- verilog/pin_sync.sv
// Two-stage synchroniser with rising-edge pulse for the photocoupler inputs
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic last_q;
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					last_q <= 1'b0;
				end else begin
					meta_q <= pinIn[i];
					sync_q <= meta_q;
					last_q <= sync_q;
				end
			end
			assign level[i] = sync_q;
			assign rise[i]  = sync_q & ~last_q;
		end
	endgenerate

endmodule

`default_nettype wire

//--- verilog/cycle_timer.sv
// Restartable cycle counter that holds its expired flag once the limit is reached
`default_nettype none

module cycle_timer #(
	parameter int unsigned LIMIT = 1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      expired
);

	localparam logic [31:0] LIM = LIMIT[31:0];

	logic [31:0] count_q;

	always_ff @(posedge clk) begin
		if (rst || restart) begin
			count_q <= 32'h0000_0000;
		end else if (count_q != LIM) begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	assign expired = (count_q == LIM);

endmodule

`default_nettype wire

//--- verilog/closed_loop_stepper_pulse_control.sv
// Pulse command, winding, resolution, alarm and completion logic of a closed-loop stepper driver
`default_nettype none

module closed_loop_stepper_pulse_control #(
	parameter int unsigned SETTLE_CYCLES = stepper_pkg::SETTLE_CYC,
	parameter int unsigned BRAKE_CYCLES  = stepper_pkg::BRAKE_CYC,
	parameter int unsigned BLINK_CYCLES  = stepper_pkg::BLINK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stepPulsePin,
	input  wire logic        dirPin,
	input  wire logic        windingReleasePin,
	input  wire logic        resMultPin,
	input  wire logic        alarmClearPin,
	input  wire logic        dualPulseModeSw,
	input  wire logic        base500Sw,
	input  wire logic        tenfoldSw,
	input  wire logic [6:0]  faultIn,
	input  wire logic [31:0] rotorPos,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             irq,
	output logic             stepCw,
	output logic             stepCcw,
	output logic             windingsOn,
	output logic             positioningDone,
	output logic             alarmOut,
	output logic             alarmLed,
	output logic             brakeReleaseOk
);

	// ------------------------------------------------------------
	// Pin front end
	// ------------------------------------------------------------
	logic [stepper_pkg::PIN_COUNT-1:0] pinLevel;
	logic [stepper_pkg::PIN_COUNT-1:0] pinRise;

	// Photocoupler conducting reads as 1; an open input pulls to 0 upstream
	pin_sync #(
		.WIDTH (stepper_pkg::PIN_COUNT)
	) u_sync (
		.clk   (clk),
		.rst   (rst),
		.pinIn ({tenfoldSw, base500Sw, dualPulseModeSw, alarmClearPin,
		         resMultPin, windingReleasePin, dirPin, stepPulsePin}), // RL12
		.level (pinLevel),
		.rise  (pinRise)
	);

	logic dualMode;
	logic releaseOn;
	logic clearRise;
	assign dualMode  = pinLevel[stepper_pkg::PIN_DUAL];
	assign releaseOn = pinLevel[stepper_pkg::PIN_REL];
	assign clearRise = pinRise[stepper_pkg::PIN_ACLR];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	stepper_pkg::alarm_state_t state_q;
	stepper_pkg::alarm_state_t state_d;
	logic [6:0]  cause_q;
	logic [31:0] command_q;
	logic [31:0] deviation_q;
	logic [31:0] mask_q;
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] regRdata_q;
	logic        irq_q;
	logic        stepCw_q;
	logic        stepCcw_q;
	logic        windingsOn_q;
	logic        done_q;
	logic        alarmOut_q;
	logic        alarmLed_q;
	logic        brakeOk_q;

	// ------------------------------------------------------------
	// Step decode
	// ------------------------------------------------------------
	logic cwEvent;
	logic ccwEvent;
	logic stepAccept;
	logic cwTake;
	logic ccwTake;

	always_comb begin
		if (dualMode) begin
			cwEvent  = pinRise[stepper_pkg::PIN_STEP]; // RL2
			ccwEvent = pinRise[stepper_pkg::PIN_DIR]; // RL2
		end else begin
			cwEvent  = pinRise[stepper_pkg::PIN_STEP] & pinLevel[stepper_pkg::PIN_DIR]; // RL1
			ccwEvent = pinRise[stepper_pkg::PIN_STEP] & ~pinLevel[stepper_pkg::PIN_DIR]; // RL1
		end
	end

	// Pulses arriving while the shaft is free are dropped; simultaneous dual pulses cancel
	assign stepAccept = windingsOn_q & ~releaseOn;
	assign cwTake     = stepAccept & cwEvent & ~ccwEvent;
	assign ccwTake    = stepAccept & ccwEvent & ~cwEvent;

	// ------------------------------------------------------------
	// Resolution in effect
	// ------------------------------------------------------------
	logic        tenfold;
	logic [31:0] stepSize;

	// The switch wins over the input; the input only matters at the base settings
	assign tenfold = pinLevel[stepper_pkg::PIN_SWX10] | pinLevel[stepper_pkg::PIN_MULT]; // RL5 RL6

	always_comb begin
		if (pinLevel[stepper_pkg::PIN_B500]) begin
			stepSize = tenfold ? stepper_pkg::STEP_FINE_500 : stepper_pkg::STEP_BASE_500; // RL5
		end else begin
			stepSize = tenfold ? stepper_pkg::STEP_FINE_1000 : stepper_pkg::STEP_BASE_1000; // RL5
		end
	end

	// ------------------------------------------------------------
	// Commanded position and deviation
	// ------------------------------------------------------------
	// Tracking the rotor while free keeps the deviation at zero, so no jump on re-energise
	always_ff @(posedge clk) begin
		if (rst) begin
			command_q <= 32'h0000_0000;
		end else if (releaseOn || !windingsOn_q) begin
			command_q <= rotorPos; // RL4
		end else if (cwTake) begin
			command_q <= command_q + stepSize; // RL15
		end else if (ccwTake) begin
			command_q <= command_q - stepSize; // RL15
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			deviation_q <= 32'h0000_0000;
		end else begin
			deviation_q <= command_q - rotorPos;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stepCw_q  <= 1'b0;
			stepCcw_q <= 1'b0;
		end else begin
			stepCw_q  <= cwTake; // RL1 RL2
			stepCcw_q <= ccwTake; // RL1 RL2
		end
	end

	// ------------------------------------------------------------
	// Positioning completion
	// ------------------------------------------------------------
	logic        settled;
	logic [31:0] devMag;
	logic        devSmall;
	logic        doneNext;

	cycle_timer #(
		.LIMIT (SETTLE_CYCLES)
	) u_settle (
		.clk     (clk),
		.rst     (rst),
		.restart (cwEvent | ccwEvent),
		.expired (settled)
	);

	assign devMag   = deviation_q[31] ? (32'h0000_0000 - deviation_q) : deviation_q;
	assign devSmall = devMag < stepper_pkg::WINDOW_UNITS;
	assign doneNext = devSmall & settled & windingsOn_q & (state_q == stepper_pkg::ST_RUN); // RL9

	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= doneNext; // RL10
		end
	end

	// ------------------------------------------------------------
	// Protection alarm
	// ------------------------------------------------------------
	logic anyFault;
	logic hardFault;
	assign anyFault  = |faultIn;
	assign hardFault = |(faultIn & stepper_pkg::FAULT_NOCLEAR);

	always_comb begin
		state_d = state_q;
		case (state_q)
			stepper_pkg::ST_RUN: begin
				if (hardFault) begin
					state_d = stepper_pkg::ST_LOCKED; // RL8
				end else if (anyFault) begin
					state_d = stepper_pkg::ST_ALARM; // RL13
				end
			end
			stepper_pkg::ST_ALARM: begin
				if (hardFault) begin
					state_d = stepper_pkg::ST_LOCKED; // RL8
				end else if (clearRise && !anyFault) begin
					state_d = stepper_pkg::ST_RUN; // RL7
				end
			end
			stepper_pkg::ST_LOCKED: begin
				state_d = stepper_pkg::ST_LOCKED; // RL8
			end
			default: begin
				state_d = stepper_pkg::ST_LOCKED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= stepper_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// A fault present in the clear cycle keeps its cause bit
	always_ff @(posedge clk) begin
		if (rst) begin
			cause_q <= 7'h00;
		end else if (state_d == stepper_pkg::ST_RUN) begin
			cause_q <= 7'h00;
		end else begin
			cause_q <= cause_q | faultIn;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			windingsOn_q <= 1'b0;
			alarmOut_q   <= 1'b0;
		end else begin
			windingsOn_q <= ~releaseOn & (state_d == stepper_pkg::ST_RUN); // RL3 RL13
			alarmOut_q   <= (state_d == stepper_pkg::ST_RUN); // RL14
		end
	end

	logic blinkTick;

	cycle_timer #(
		.LIMIT (BLINK_CYCLES)
	) u_blink (
		.clk     (clk),
		.rst     (rst),
		.restart (blinkTick),
		.expired (blinkTick)
	);

	// Hard faults light steadily so a clearable alarm is told apart at a glance
	always_ff @(posedge clk) begin
		if (rst) begin
			alarmLed_q <= 1'b0;
		end else begin
			case (state_q)
				stepper_pkg::ST_ALARM:  alarmLed_q <= alarmLed_q ^ blinkTick; // RL13
				stepper_pkg::ST_LOCKED: alarmLed_q <= 1'b1;
				default:                alarmLed_q <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Brake release permission
	// ------------------------------------------------------------
	logic brakeTimeUp;

	cycle_timer #(
		.LIMIT (BRAKE_CYCLES)
	) u_brake (
		.clk     (clk),
		.rst     (rst),
		.restart (1'b0),
		.expired (brakeTimeUp)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			brakeOk_q <= 1'b0;
		end else begin
			brakeOk_q <= brakeTimeUp; // RL11
		end
	end

	// ------------------------------------------------------------
	// Register port and interrupt
	// ------------------------------------------------------------
	logic [31:0] events;
	logic        statusRead;

	always_comb begin
		events = 32'h0000_0000;
		events[stepper_pkg::EV_DONE]    = doneNext & ~done_q;
		events[stepper_pkg::EV_ALARM]   = (state_q == stepper_pkg::ST_RUN) &&
		                                  (state_d != stepper_pkg::ST_RUN);
		events[stepper_pkg::EV_CLEARED] = (state_q == stepper_pkg::ST_ALARM) &&
		                                  (state_d == stepper_pkg::ST_RUN);
	end

	// Read clears, but an event in the same cycle survives
	assign statusRead = regRd && (regAddr == stepper_pkg::REG_STATUS);
	assign status_d   = (statusRead ? 32'h0000_0000 : status_q) | events;

	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= 32'h0000_0000;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q    <= |(status_d & mask_q);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q <= 32'h0000_0000;
		end else if (regWr && regAddr == stepper_pkg::REG_MASK) begin
			mask_q <= regWdata & {{(32-stepper_pkg::EV_COUNT){1'b0}},
			                      {stepper_pkg::EV_COUNT{1'b1}}};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !regRd) begin
			regRdata_q <= 32'h0000_0000;
		end else begin
			case (regAddr)
				stepper_pkg::REG_STATUS:    regRdata_q <= status_q;
				stepper_pkg::REG_MASK:      regRdata_q <= mask_q;
				stepper_pkg::REG_POSITION:  regRdata_q <= command_q;
				stepper_pkg::REG_DEVIATION: regRdata_q <= deviation_q;
				stepper_pkg::REG_STATE:     regRdata_q <= {16'h0000, 1'b0, cause_q,
				                                           dualMode, tenfold, windingsOn_q,
				                                           done_q, 1'b0, state_q};
				default:                    regRdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign regRdata        = regRdata_q;
	assign irq             = irq_q;
	assign stepCw          = stepCw_q;
	assign stepCcw         = stepCcw_q;
	assign windingsOn      = windingsOn_q;
	assign positioningDone = done_q;
	assign alarmOut        = alarmOut_q;
	assign alarmLed        = alarmLed_q;
	assign brakeReleaseOk  = brakeOk_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_release_seen;
		releaseOn;
	endsequence

	sequence s_free_shaft;
		!windingsOn_q;
	endsequence

	chk_cw_single: assert property (!dualMode && cwTake |=> stepCw_q && !stepCcw_q) // RL1
		else $error("single mode step did not go clockwise");
	chk_ccw_dual: assert property (dualMode && ccwTake |=> stepCcw_q && !stepCw_q) // RL2
		else $error("dual mode ccw pulse lost");
	chk_release_off: assert property (s_release_seen |=> s_free_shaft) // RL3
		else $error("windings stayed on under release");
	chk_release_zero: assert property (s_release_seen ##1 1 |=> deviation_q == 32'h0000_0000
	                                   || $past(rotorPos) != $past(rotorPos, 2)) // RL4
		else $error("deviation not cleared by release");
	chk_step_scale: assert property (cwTake |=> command_q == $past(command_q) + $past(stepSize)) // RL15
		else $error("commanded position not scaled by resolution");
	chk_tenfold_sw: assert property (pinLevel[stepper_pkg::PIN_SWX10] && !pinLevel[stepper_pkg::PIN_B500]
	                                 |-> stepSize == stepper_pkg::STEP_FINE_1000) // RL6
		else $error("multiplier input changed tenfold setting");
	chk_mult_base: assert property (pinLevel[stepper_pkg::PIN_MULT] && pinLevel[stepper_pkg::PIN_B500]
	                                |-> stepSize == stepper_pkg::STEP_FINE_500) // RL5
		else $error("multiplier did not raise resolution");
	chk_alarm_clear: assert property (state_q == stepper_pkg::ST_ALARM && clearRise && !anyFault
	                                  |=> state_q == stepper_pkg::ST_RUN && alarmOut_q) // RL7
		else $error("alarm clear did not cancel alarm");
	chk_locked_stays: assert property (state_q == stepper_pkg::ST_LOCKED
	                                   |=> state_q == stepper_pkg::ST_LOCKED [*2]) // RL8
		else $error("hard alarm left locked state");
	chk_done_cause: assert property ($rose(done_q) |-> $past(devSmall && settled)) // RL9
		else $error("completion without settled small deviation");
	chk_done_pulse: assert property (cwEvent |-> ##2 !done_q [*2]) // RL10
		else $error("completion asserted during pulse input");
	chk_alarm_stop: assert property (anyFault |=> !alarmOut_q && !windingsOn_q) // RL13 RL14
		else $error("fault did not open alarm and free windings");

endmodule

`default_nettype wire

//--- dv/pulse_source.sv
// Behavioural pulse controller driving the step link and timing the brake release
`default_nettype none

module pulse_source #(
	parameter int unsigned BRAKE_WAIT = 100
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic       dual,
	input  wire logic       cw,
	input  wire logic [7:0] count,
	output logic            stepPin,
	output logic            dirPin,
	output logic            busy,
	output logic            brakeFree
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  leftQ;
	logic [2:0]  phaseQ;
	logic        cwQ;
	logic        dualQ;
	int unsigned upQ;
	logic        high;

	always_ff @(posedge clk) begin
		if (rst || start) begin
			leftQ <= rst ? 8'h00 : count;
			phaseQ <= 3'h0;
			cwQ <= cw;
			dualQ <= dual;
		end else if (leftQ != 8'h00) begin
			phaseQ <= phaseQ + 3'h1;
			if (phaseQ == 3'h7) begin
				leftQ <= leftQ - 8'h01;
			end
		end
	end

	// Direction settles four cycles before each pulse; idle step lines stay off, while in single mode the direction line keeps its level
	assign high = (leftQ != 8'h00) && phaseQ[2];
	assign stepPin = dualQ ? (high && cwQ) : high;
	assign dirPin = dualQ ? (high && !cwQ) : cwQ;
	assign busy = leftQ != 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			upQ <= 0;
		end else if (upQ < BRAKE_WAIT) begin
			upQ <= upQ + 1;
		end
	end

	// The load would drop if the brake opened before the driver holds it
	assign brakeFree = upQ >= BRAKE_WAIT;
endmodule

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the closed-loop stepper pulse control block
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic        dual;
		logic        cw;
		logic [7:0]  n;
		logic        b500;
		logic        sw10;
		logic        mult;
		logic [31:0] delta;
	} row_t;

	localparam int unsigned SETTLE = 50;
	localparam row_t ROWS [6] = '{
		'{1'b0, 1'b1, 8'h03, 1'b0, 1'b0, 1'b0, 32'h0000_001e},
		'{1'b0, 1'b0, 8'h02, 1'b1, 1'b0, 1'b0, 32'hffff_ffd8},
		'{1'b1, 1'b1, 8'h04, 1'b0, 1'b0, 1'b1, 32'h0000_0004},
		'{1'b1, 1'b0, 8'h03, 1'b1, 1'b0, 1'b1, 32'hffff_fffa},
		'{1'b0, 1'b1, 8'h02, 1'b0, 1'b1, 1'b1, 32'h0000_0002},
		'{1'b1, 1'b1, 8'h01, 1'b1, 1'b1, 1'b0, 32'h0000_0002}
	};

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic        dual = 1'b0;
	logic        cw = 1'b0;
	logic [7:0]  count = 8'h00;
	logic        relPin = 1'b0;
	logic        resMult = 1'b0;
	logic        aclPin = 1'b0;
	logic        base500 = 1'b0;
	logic        tenfold = 1'b0;
	logic [6:0]  faultIn = 7'h00;
	logic [31:0] rotorPos = 32'h0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdata, pos;
	logic        irq, stepCw, stepCcw, windingsOn, done, alarmOut, alarmLed, brakeOk;
	logic        stepPin, dirPin, busy, brakeFree, led0;
	int          badCount = 0;
	int          checks = 0;
	int          cwSeen = 0;
	int          ccwSeen = 0;
	int          cwBase, ccwBase, cycles = 0;
	int          locks [2] = '{4, 6};
	row_t        r;

	always #5 clk = ~clk;

	closed_loop_stepper_pulse_control #(.SETTLE_CYCLES(SETTLE), .BRAKE_CYCLES(100),
		.BLINK_CYCLES(8)) dut_u (.clk(clk), .rst(rst), .stepPulsePin(stepPin),
		.dirPin(dirPin), .windingReleasePin(relPin), .resMultPin(resMult),
		.alarmClearPin(aclPin), .dualPulseModeSw(dual), .base500Sw(base500),
		.tenfoldSw(tenfold), .faultIn(faultIn), .rotorPos(rotorPos), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
		.stepCw(stepCw), .stepCcw(stepCcw), .windingsOn(windingsOn), .positioningDone(done),
		.alarmOut(alarmOut), .alarmLed(alarmLed), .brakeReleaseOk(brakeOk));

	pulse_source #(.BRAKE_WAIT(100)) partner_u (.clk(clk), .rst(rst), .start(start),
		.dual(dual), .cw(cw), .count(count), .stepPin(stepPin), .dirPin(dirPin),
		.busy(busy), .brakeFree(brakeFree));

	always @(posedge clk) begin
		cwSeen += (stepCw === 1'b1);
		ccwSeen += (stepCcw === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		cmpWord({31'h0, got}, {31'h0, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		regAddr <= a;
		regWdata <= w;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		cmpWord(regRdata, exp);
	endtask

	task automatic steps(input logic dir, input logic [7:0] n);
		@(posedge clk);
		cw <= dir;
		count <= n;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
	endtask

	task automatic doReset();
		@(posedge clk);
		rst <= 1'b1;
		cyc(8);
		rst <= 1'b0;
		cyc(4);
	endtask

	initial begin
		pos = 32'h0;
		doReset();
		cmpBit(brakeOk, 1'b0);
		// ------------------------------------------------------------
		// Table of step rows
		// ------------------------------------------------------------
		foreach (ROWS[i]) begin
			r = ROWS[i];
			dual <= r.dual;
			base500 <= r.b500;
			tenfold <= r.sw10;
			resMult <= r.mult;
			cyc(8);
			cwBase = cwSeen;
			ccwBase = ccwSeen;
			steps(r.cw, r.n);
			pos = pos + r.delta;
			rotorPos <= pos;
			cyc(SETTLE - 15);
			cmpBit(done, 1'b0);
			cyc(30);
			cmpBit(done, 1'b1);
			regCheck(stepper_pkg::REG_POSITION, pos);
			cmpWord(32'(cwSeen - cwBase), r.cw ? 32'(r.n) : 32'h0);
			cmpWord(32'(ccwSeen - ccwBase), r.cw ? 32'h0 : 32'(r.n));
			$display("test row %0d done", i);
		end
		cmpBit(brakeOk, brakeFree);
		// ------------------------------------------------------------
		// Completion window, interrupt and register edges
		// ------------------------------------------------------------
		regCheck(stepper_pkg::REG_STATUS, 32'h0000_0001);
		regWrite(stepper_pkg::REG_MASK, 32'h0000_0007);
		regCheck(stepper_pkg::REG_MASK, 32'h0000_0007);
		rotorPos <= pos - 32'h0000_0032;
		cyc(6);
		cmpBit(done, 1'b0);
		regCheck(stepper_pkg::REG_DEVIATION, 32'h0000_0032);
		rotorPos <= pos - 32'h0000_0031;
		cyc(6);
		cmpBit(done, 1'b1);
		cmpBit(irq, 1'b1);
		regCheck(stepper_pkg::REG_STATUS, 32'h0000_0001);
		cyc(2);
		cmpBit(irq, 1'b0);
		regWrite(stepper_pkg::REG_MASK, 32'h0000_0000);
		rotorPos <= pos - 32'h0000_0032;
		cyc(6);
		rotorPos <= pos - 32'h0000_0031;
		cyc(6);
		cmpBit(irq, 1'b0);
		regCheck(stepper_pkg::REG_STATUS, 32'h0000_0001);
		regCheck(8'h20, 32'h0);
		regWrite(stepper_pkg::REG_POSITION, 32'h0000_1234);
		regCheck(stepper_pkg::REG_POSITION, pos);
		$display("test window and interrupt done");
		// ------------------------------------------------------------
		// Winding release drops steps and clears the deviation
		// ------------------------------------------------------------
		relPin <= 1'b1;
		cyc(6);
		cmpBit(windingsOn, 1'b0);
		cwBase = cwSeen;
		steps(1'b1, 8'h02);
		cyc(8);
		cmpWord(32'(cwSeen - cwBase), 32'h0);
		regCheck(stepper_pkg::REG_DEVIATION, 32'h0);
		rotorPos <= 32'h0000_0100;
		cyc(6);
		regCheck(stepper_pkg::REG_POSITION, 32'h0000_0100);
		relPin <= 1'b0;
		cyc(6);
		cmpBit(windingsOn, 1'b1);
		$display("test release done");
		// ------------------------------------------------------------
		// Alarms, clearable and locked
		// ------------------------------------------------------------
		faultIn <= 7'h01;
		cyc(3);
		cmpBit(alarmOut, 1'b0);
		cmpBit(windingsOn, 1'b0);
		led0 = alarmLed;
		// The blink timer runs one cycle past its limit, so nine edges hold exactly one toggle
		cyc(9);
		cmpBit(alarmLed, ~led0);
		faultIn <= 7'h00;
		aclPin <= 1'b1;
		cyc(4);
		aclPin <= 1'b0;
		cyc(8);
		cmpBit(alarmOut, 1'b1);
		foreach (locks[k]) begin
			faultIn <= 7'(1 << locks[k]);
			cyc(4);
			faultIn <= 7'h00;
			aclPin <= 1'b1;
			cyc(4);
			aclPin <= 1'b0;
			cyc(8);
			cmpBit(alarmOut, 1'b0);
			regCheck(stepper_pkg::REG_STATE, {16'h0000, 1'b0, 7'(1 << locks[k]), 8'hc4});
			doReset();
			cmpBit(alarmOut, 1'b1);
			cmpBit(brakeOk, 1'b0);
		end
		$display("test alarms done");
		end_of_test();
	end
endmodule

`default_nettype wire
